// ==== pmc_regs.svh ====
// Register map, field positions, reset values and timing constants of the power and clock control
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// Register offsets
`define PMC_ADDR_POWER_CONTROL   8'h87
`define PMC_ADDR_CLOCK_DIVIDER   8'hc7
`define PMC_ADDR_CLKO_WAKE       8'h8f

// Power control fields
`define PMC_PC_BAUD_DOUBLE       7
`define PMC_PC_FRAME_ERR_SEL     6
`define PMC_PC_LOW_VOLT          5
`define PMC_PC_POWER_ON          4
`define PMC_PC_GEN_ONE           3
`define PMC_PC_GEN_ZERO          2
`define PMC_PC_POWER_DOWN        1
`define PMC_PC_IDLE              0

// Clock-out and wake control fields
`define PMC_CW_CAPTURE_WAKE      7
`define PMC_CW_RXD_WAKE          6
`define PMC_CW_T1_WAKE           5
`define PMC_CW_T0_WAKE           4
`define PMC_CW_T1_CLKO           1
`define PMC_CW_T0_CLKO           0
`define PMC_CW_WRITE_MASK        8'hf3

// Clock divider field width and mask
`define PMC_DIV_MASK             8'h07
`define PMC_DIV_MAX              8'h7f

// Reset values
`define PMC_RST_POWER_CONTROL    8'h00
`define PMC_RST_CLOCK_DIVIDER    8'h00
`define PMC_RST_CLKO_WAKE        8'h00
`define PMC_RST_ZERO8            8'h00

// Reset pulse needed to leave idle, in oscillator periods
`define PMC_IDLE_RESET_PERIODS   24

`endif

// ==== pmc_pkg.sv ====
// Types shared by the power and clock control block
`default_nettype none
package pmc_pkg;
	// Power state of the core
	typedef enum logic [1:0] {
		PMC_RUN,
		PMC_IDLE,
		PMC_POWER_DOWN
	} pmc_state_t;
endpackage
`default_nettype wire

// ==== pmc_clk_div.sv ====
// System clock divider producing a one-cycle enable at 2 to the power of the code
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_clk_div (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Divide code
	input  wire logic [2:0] i_code,
	// Divided enable
	output logic            o_tick
);
	logic [6:0] cnt_q;   // Free running prescaler
	logic [6:0] cnt_d;
	logic [6:0] limit;   // Terminal count for the code
	logic       wrap;

	// Ratio is 2**code, so terminal count is 2**code minus one
	assign limit = 7'((8'h01 << i_code) - 8'h01);
	// A code change lowers the limit; >= stops a runaway wrap
	assign wrap  = (cnt_q >= limit);
	assign cnt_d = wrap ? 7'h00 : 7'(cnt_q + 7'h01);

	// Prescaler counter
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_q  <= 7'h00;
			o_tick <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			o_tick <= wrap;
		end
	end
endmodule
`default_nettype wire

// ==== pmc_power_clock_ctrl.sv ====
// Power mode control, slow-down divider and timer clock outputs
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module pmc_power_clock_ctrl (
	// Clock and reset
	input  wire logic       I_CLK,
	input  wire logic       I_RST,
	// Register port
	input  wire logic [7:0] I_ADDR,
	input  wire logic [7:0] I_WDATA,
	input  wire logic       I_WR,
	input  wire logic       I_RD,
	output logic      [7:0] O_RDATA,
	// Timer status from the timer cores
	input  wire logic       I_T0_OVERFLOW,
	input  wire logic       I_T1_OVERFLOW,
	// Enabled interrupt request and interrupt sources
	input  wire logic       I_IRQ_PENDING,
	input  wire logic       I_T0_IRQ,
	input  wire logic       I_T1_IRQ,
	input  wire logic       I_UART_IRQ,
	// Pins and analog status, asynchronous
	input  wire logic       I_LOW_VOLTAGE,
	input  wire logic       I_POWER_CYCLED,
	input  wire logic [8:0] I_WAKE_PINS,
	input  wire logic       I_CAPTURE_IDLE_RUN,
	// Clock-out port latches
	output logic            O_CLKOUT0,
	output logic            O_CLKOUT1,
	// Clock gating and power state
	output logic            O_SYS_TICK,
	output logic            O_CPU_CLK_EN,
	output logic            O_PERIPH_CLK_EN,
	output logic            O_CAPTURE_CLK_EN,
	output logic            O_OSC_STOP,
	// Serial configuration
	output logic            O_BAUD_DOUBLE,
	output logic            O_FRAME_ERR_SEL
);
	// Register state
	logic [7:0] power_control_q;      // Flags and mode bits
	logic [7:0] clock_divider_q;      // Divide code in low bits
	logic [7:0] clko_wake_q;          // Clock-out and wake enables
	pmc_pkg::pmc_state_t state_q;     // Power state
	pmc_pkg::pmc_state_t state_d;
	logic       clko0_q;              // Clock-out latches
	logic       clko1_q;
	logic [7:0] rdata_d;

	// Two-stage synchronisers for asynchronous inputs
	logic [8:0] wake_s1_q;
	logic [8:0] wake_s2_q;
	logic       lv_s1_q;
	logic       lv_s2_q;
	logic       pc_s1_q;
	logic       pc_s2_q;
	logic       cap_s1_q;
	logic       cap_s2_q;
	logic [8:0] wake_prev_q;          // For activity detection

	// Address decode
	wire wr_pc  = I_WR && (I_ADDR == `PMC_ADDR_POWER_CONTROL);
	wire wr_div = I_WR && (I_ADDR == `PMC_ADDR_CLOCK_DIVIDER);
	wire wr_cw  = I_WR && (I_ADDR == `PMC_ADDR_CLKO_WAKE);

	// Slow-down tick from the divider
	logic div_tick;
	pmc_clk_div u_div (
		.i_clk  (I_CLK),
		.i_rst  (I_RST),
		.i_code (clock_divider_q[2:0]),
		.o_tick (div_tick)
	);

	// Pin activity: any edge on a synchronised wake pin
	wire pin_activity = |(wake_s2_q ^ wake_prev_q);
	// Interrupt sources that end idle
	wire idle_wake = I_IRQ_PENDING | I_T0_IRQ | I_T1_IRQ | I_UART_IRQ;
	// Hardware events setting flags
	wire lv_event = lv_s2_q;
	wire pc_event = pc_s2_q;
	// Mode requests from a power control write
	wire req_pd   = wr_pc && I_WDATA[`PMC_PC_POWER_DOWN];
	wire req_idle = wr_pc && I_WDATA[`PMC_PC_IDLE] && !req_pd;

	// Next power state
	always_comb begin
		state_d = state_q;
		case (state_q)
			// Running: a power control write may pick a low-power mode
			pmc_pkg::PMC_RUN: begin
				if (req_pd) begin
					state_d = pmc_pkg::PMC_POWER_DOWN;
				end else if (req_idle) begin
					state_d = pmc_pkg::PMC_IDLE;
				end
			end
			// Idle: any enabled interrupt or pin activity resumes the CPU
			pmc_pkg::PMC_IDLE: begin
				if (idle_wake || pin_activity) begin
					state_d = pmc_pkg::PMC_RUN;
				end
			end
			// Power-down: only pin activity restarts the clocks
			pmc_pkg::PMC_POWER_DOWN: begin
				if (pin_activity) begin
					state_d = pmc_pkg::PMC_RUN;
				end
			end
			// Unused encoding falls back to running
			default: begin
				state_d = pmc_pkg::PMC_RUN;
			end
		endcase
	end

	// Next power control value; hardware set beats software clear
	logic [7:0] pc_d;
	always_comb begin
		pc_d = power_control_q;
		// Software write first; the hardware sets below override it
		if (wr_pc) begin
			pc_d = I_WDATA;
		end
		if (lv_event) begin
			pc_d[`PMC_PC_LOW_VOLT] = 1'b1;
		end
		if (pc_event) begin
			pc_d[`PMC_PC_POWER_ON] = 1'b1;
		end
		// Mode bits mirror the state; a wake clears them by hardware
		pc_d[`PMC_PC_POWER_DOWN] = (state_d == pmc_pkg::PMC_POWER_DOWN);
		pc_d[`PMC_PC_IDLE]       = (state_d == pmc_pkg::PMC_IDLE);
	end

	// Reset image; the power-on flag rides through reset and may still be set
	logic [7:0] pc_rst;
	always_comb begin
		pc_rst                   = `PMC_RST_POWER_CONTROL;
		pc_rst[`PMC_PC_POWER_ON] = power_control_q[`PMC_PC_POWER_ON] | pc_event;
	end

	// Read mux; unmapped addresses read as zero
	always_comb begin
		case (I_ADDR)
			`PMC_ADDR_POWER_CONTROL: rdata_d = power_control_q;
			`PMC_ADDR_CLOCK_DIVIDER: rdata_d = clock_divider_q & `PMC_DIV_MASK;
			`PMC_ADDR_CLKO_WAKE:     rdata_d = clko_wake_q;
			default:                 rdata_d = `PMC_RST_ZERO8;
		endcase
	end

	// Synchronisers; first stage feeds only the second
	always_ff @(posedge I_CLK) begin
		wake_s1_q <= I_WAKE_PINS;
		wake_s2_q <= wake_s1_q;
		lv_s1_q   <= I_LOW_VOLTAGE;
		lv_s2_q   <= lv_s1_q;
		pc_s1_q   <= I_POWER_CYCLED;
		pc_s2_q   <= pc_s1_q;
		cap_s1_q  <= I_CAPTURE_IDLE_RUN;
		cap_s2_q  <= cap_s1_q;
	end

	// Previous synchronised pin levels; no reset, so a pin that idles
	// high is not taken for an edge in the first cycle after reset
	always_ff @(posedge I_CLK) begin
		wake_prev_q <= wake_s2_q;
	end

	// Registers and power state; the power-on flag survives reset
	// so software can tell a power cycle from other resets
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			power_control_q <= pc_rst;
			clock_divider_q <= `PMC_RST_CLOCK_DIVIDER;
			clko_wake_q     <= `PMC_RST_CLKO_WAKE;
			state_q         <= pmc_pkg::PMC_RUN;
		end else begin
			power_control_q <= pc_d;
			state_q         <= state_d;
			if (wr_div) begin
				clock_divider_q <= I_WDATA & `PMC_DIV_MASK;
			end
			if (wr_cw) begin
				clko_wake_q <= I_WDATA & `PMC_CW_WRITE_MASK;
			end
		end
	end

	// Clock-out latches toggle per overflow; overflow pulses already
	// carry the timer-mode, speed and reload dividing
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			clko0_q <= 1'b0;
			clko1_q <= 1'b0;
		end else begin
			if (clko_wake_q[`PMC_CW_T0_CLKO] && I_T0_OVERFLOW) begin
				clko0_q <= !clko0_q;
			end
			if (clko_wake_q[`PMC_CW_T1_CLKO] && I_T1_OVERFLOW) begin
				clko1_q <= !clko1_q;
			end
		end
	end

	// Output flops
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_RDATA          <= `PMC_RST_ZERO8;
			O_SYS_TICK       <= 1'b0;
			O_CPU_CLK_EN     <= 1'b0;
			O_PERIPH_CLK_EN  <= 1'b0;
			O_CAPTURE_CLK_EN <= 1'b0;
			O_OSC_STOP       <= 1'b0;
			O_CLKOUT0        <= 1'b0;
			O_CLKOUT1        <= 1'b0;
			O_BAUD_DOUBLE    <= 1'b0;
			O_FRAME_ERR_SEL  <= 1'b0;
		end else begin
			O_RDATA          <= I_RD ? rdata_d : `PMC_RST_ZERO8;
			O_SYS_TICK       <= div_tick && (state_d != pmc_pkg::PMC_POWER_DOWN);
			// CPU stops in idle; its state and port latches simply hold
			O_CPU_CLK_EN     <= div_tick && (state_d == pmc_pkg::PMC_RUN);
			O_PERIPH_CLK_EN  <= div_tick && (state_d != pmc_pkg::PMC_POWER_DOWN);
			O_CAPTURE_CLK_EN <= div_tick && ((state_d == pmc_pkg::PMC_RUN) ||
				((state_d == pmc_pkg::PMC_IDLE) && cap_s2_q));
			O_OSC_STOP       <= (state_d == pmc_pkg::PMC_POWER_DOWN);
			O_CLKOUT0        <= clko0_q;
			O_CLKOUT1        <= clko1_q;
			O_BAUD_DOUBLE    <= pc_d[`PMC_PC_BAUD_DOUBLE];
			O_FRAME_ERR_SEL  <= pc_d[`PMC_PC_FRAME_ERR_SEL];
		end
	end

	// Assertions
	// Steps of a power-down entry and of a wake by pin activity
	sequence s_pd_enter;
		(state_q == pmc_pkg::PMC_RUN) && req_pd;
	endsequence
	sequence s_pd_settled;
		(state_q == pmc_pkg::PMC_POWER_DOWN) && O_OSC_STOP && !O_PERIPH_CLK_EN;
	endsequence
	sequence s_pin_wake;
		(state_q == pmc_pkg::PMC_POWER_DOWN) && pin_activity;
	endsequence
	sequence s_running;
		(state_q == pmc_pkg::PMC_RUN) && !O_OSC_STOP;
	endsequence

	// Steps of an idle entry, and an idle that nothing ends this cycle
	sequence s_idle_enter;
		(state_q == pmc_pkg::PMC_RUN) && req_idle;
	endsequence
	sequence s_idle_settled;
		(state_q == pmc_pkg::PMC_IDLE) && power_control_q[`PMC_PC_IDLE] && !O_CPU_CLK_EN;
	endsequence
	sequence s_idle_stays;
		(state_q == pmc_pkg::PMC_IDLE) && !idle_wake && !pin_activity;
	endsequence

	// Power-down entry, exit and precedence
	AST_PD_WINS: assert property (@(posedge I_CLK) disable iff (I_RST)
		(state_q == pmc_pkg::PMC_RUN && wr_pc && I_WDATA[`PMC_PC_POWER_DOWN] && I_WDATA[`PMC_PC_IDLE])
		|=> (state_q == pmc_pkg::PMC_POWER_DOWN))
		else $error("power-down not chosen over idle");
	AST_OSC_STOP: assert property (@(posedge I_CLK) disable iff (I_RST)
		(state_q == pmc_pkg::PMC_POWER_DOWN) |-> O_OSC_STOP)
		else $error("oscillator running in power-down");
	AST_PD_ENTRY: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_pd_enter |=> s_pd_settled)
		else $error("power-down entry incomplete");
	AST_PD_WAKE: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_pin_wake |=> s_running)
		else $error("pin activity did not end power-down");

	// Idle entry, clock gating and exit
	AST_IDLE_ENTRY: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_idle_enter |=> s_idle_settled)
		else $error("idle entry incomplete");
	AST_IDLE_CPU: assert property (@(posedge I_CLK) disable iff (I_RST)
		(state_q == pmc_pkg::PMC_IDLE) |-> !O_CPU_CLK_EN)
		else $error("cpu clocked in idle");
	AST_IDLE_EXIT: assert property (@(posedge I_CLK) disable iff (I_RST)
		(state_q == pmc_pkg::PMC_IDLE && I_IRQ_PENDING)
		|=> (state_q == pmc_pkg::PMC_RUN && !power_control_q[`PMC_PC_IDLE]))
		else $error("interrupt did not end idle");
	AST_IRQ_WAKE: assert property (@(posedge I_CLK) disable iff (I_RST)
		((state_q == pmc_pkg::PMC_IDLE) && (I_T0_IRQ || I_T1_IRQ || I_UART_IRQ)) |=> (state_q == pmc_pkg::PMC_RUN))
		else $error("timer or uart interrupt did not end idle");
	AST_CAP_RUN: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_idle_stays ##0 (cap_s2_q && div_tick) |=> O_CAPTURE_CLK_EN)
		else $error("capture array paused in idle");
	AST_CAP_HOLD: assert property (@(posedge I_CLK) disable iff (I_RST)
		s_idle_stays ##0 !cap_s2_q |=> !O_CAPTURE_CLK_EN)
		else $error("capture array clocked in idle");

	// Hardware-set flags
	AST_LV_SET: assert property (@(posedge I_CLK) disable iff (I_RST)
		lv_s2_q |=> power_control_q[`PMC_PC_LOW_VOLT])
		else $error("low-voltage flag not set");
	AST_POF_SET: assert property (@(posedge I_CLK)
		pc_s2_q |=> power_control_q[`PMC_PC_POWER_ON])
		else $error("power-on flag not set");
	AST_POF_KEEP: assert property (@(posedge I_CLK)
		(power_control_q[`PMC_PC_POWER_ON] && !wr_pc) |=> power_control_q[`PMC_PC_POWER_ON])
		else $error("power-on flag lost without a write");

	// Clock outputs
	AST_T0_TOGGLE: assert property (@(posedge I_CLK) disable iff (I_RST)
		(clko_wake_q[`PMC_CW_T0_CLKO] && I_T0_OVERFLOW) |=> ##1 (O_CLKOUT0 != $past(O_CLKOUT0)))
		else $error("clock-out 0 did not toggle");
	AST_T1_HOLD: assert property (@(posedge I_CLK) disable iff (I_RST)
		!clko_wake_q[`PMC_CW_T1_CLKO] |=> $stable(clko1_q))
		else $error("clock-out 1 moved while disabled");

	// Register port
	AST_RD_ZERO: assert property (@(posedge I_CLK) disable iff (I_RST)
		!I_RD |=> (O_RDATA == `PMC_RST_ZERO8))
		else $error("read data outside read cycle");
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the power and clock control block
`timescale 1ns/1ps
`default_nettype none
`include "pmc_regs.svh"
module tb;
	// Clock, reset and register port drive
	logic       clk   = 1'b0;
	logic       rst   = 1'b1;
	logic [7:0] addr  = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr    = 1'b0;
	logic       rd    = 1'b0;
	logic [7:0] rdata;
	// Timer, interrupt and pin stimulus
	logic       ov0 = 1'b0;
	logic       ov1 = 1'b0;
	logic [3:0] irqs = 4'h0;
	logic [1:0] flags = 2'b10;   // Power cycle present at start-up
	logic [8:0] pins = 9'h000;
	logic       cap_run = 1'b0;
	// Observed outputs
	logic       clko0, clko1, tick, cpu_en, per_en, cap_en, osc_stop, baud, fe_sel;
	// Bench model and bookkeeping
	integer     failures = 0;
	integer     n_checks = 0;
	integer     seed     = 32'hc930;
	integer     n_cpu, n_per, n_cap, n_tick, b, k, i;
	logic [7:0] d, v;
	logic       m0, m1, r0, r1;

	// Free-running 250 MHz clock
	always #2 clk = ~clk;

	pmc_power_clock_ctrl uut (
		.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
		.I_T0_OVERFLOW(ov0), .I_T1_OVERFLOW(ov1), .I_IRQ_PENDING(irqs[0]), .I_T0_IRQ(irqs[1]),
		.I_T1_IRQ(irqs[2]), .I_UART_IRQ(irqs[3]), .I_LOW_VOLTAGE(flags[0]), .I_POWER_CYCLED(flags[1]),
		.I_WAKE_PINS(pins), .I_CAPTURE_IDLE_RUN(cap_run), .O_CLKOUT0(clko0), .O_CLKOUT1(clko1),
		.O_SYS_TICK(tick), .O_CPU_CLK_EN(cpu_en), .O_PERIPH_CLK_EN(per_en), .O_CAPTURE_CLK_EN(cap_en),
		.O_OSC_STOP(osc_stop), .O_BAUD_DOUBLE(baud), .O_FRAME_ERR_SEL(fe_sel)
	);

	// One compare for every byte-wide result; case equality keeps unknowns out
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks = n_checks + 1;
		if (got !== exp) begin
			failures = failures + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Single-cycle write strobe; the gap edge avoids a double assignment
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] val);
		@(posedge clk);
		addr  <= a;
		wdata <= val;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] val);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		val = rdata;
	endtask

	// Counts enable pulses over a window, sampled once edges have settled
	task automatic count(input integer n);
		n_cpu = 0;
		n_per = 0;
		n_cap = 0;
		n_tick = 0;
		repeat (n) begin
			@(posedge clk);
			#1;
			n_cpu = n_cpu + cpu_en;
			n_per = n_per + per_en;
			n_cap = n_cap + cap_en;
			n_tick = n_tick + tick;
		end
	endtask

	// Verdict and end of run
	task automatic close_out;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the roughly three thousand cycles of the sequence
	initial begin
		#200000;
		failures = failures + 1;
		close_out();
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst   <= 1'b0;
		flags <= 2'b00;
		// Reset values, then an unmapped place that must read zero
		rd_reg(`PMC_ADDR_POWER_CONTROL, d);
		chk(d, `PMC_RST_POWER_CONTROL | 8'(1 << `PMC_PC_POWER_ON));
		rd_reg(`PMC_ADDR_CLOCK_DIVIDER, d);
		chk(d, `PMC_RST_CLOCK_DIVIDER);
		rd_reg(`PMC_ADDR_CLKO_WAKE, d);
		chk(d, `PMC_RST_CLKO_WAKE);
		wr_reg(8'h55, 8'hff);
		rd_reg(8'h55, d);
		chk(d, 8'h00);
		// Every divide code; window of 128 holds whole periods for all codes
		for (k = 0; k < 8; k++) begin
			v = (8'($random(seed)) & 8'hf8) | 8'(k);
			wr_reg(`PMC_ADDR_CLOCK_DIVIDER, v);
			rd_reg(`PMC_ADDR_CLOCK_DIVIDER, d);
			chk(d, v & `PMC_DIV_MASK);
			repeat (140) @(posedge clk);
			count(128);
			chk(8'(n_tick), 8'(128 >> k));
			chk(8'(n_cpu), 8'(128 >> k));
		end
		wr_reg(`PMC_ADDR_CLOCK_DIVIDER, 8'h00);
		// Serial configuration bits, all four combinations
		for (k = 0; k < 4; k++) begin
			wr_reg(`PMC_ADDR_POWER_CONTROL, 8'(k << 6));
			rd_reg(`PMC_ADDR_POWER_CONTROL, d);
			chk(d, 8'(k << 6));
			chk({6'h00, baud, fe_sel}, 8'(k));
		end
		wr_reg(`PMC_ADDR_POWER_CONTROL, 8'h00);
		// Hardware-set flags survive until software clears them
		for (k = 0; k < 2; k++) begin
			@(posedge clk);
			flags <= 2'(1 << k);
			repeat (4) @(posedge clk);
			flags <= 2'b00;
			repeat (4) @(posedge clk);
			rd_reg(`PMC_ADDR_POWER_CONTROL, d);
			chk(d, 8'(8'h20 >> k));
			wr_reg(`PMC_ADDR_POWER_CONTROL, 8'h00);
			rd_reg(`PMC_ADDR_POWER_CONTROL, d);
			chk(d, 8'h00);
		end
		// Power cycle in idle, then a reset long enough to end idle; the power-on flag survives it
		wr_reg(`PMC_ADDR_POWER_CONTROL, 8'h01);
		@(posedge clk);
		flags <= 2'b10;
		repeat (4) @(posedge clk);
		flags <= 2'b00;
		rst   <= 1'b1;
		repeat (`PMC_IDLE_RESET_PERIODS) @(posedge clk);
		rst   <= 1'b0;
		rd_reg(`PMC_ADDR_POWER_CONTROL, d);
		chk(d, 8'(1 << `PMC_PC_POWER_ON));
		count(16);
		chk(8'(n_cpu), 8'h10);
		wr_reg(`PMC_ADDR_POWER_CONTROL, 8'h00);
		rd_reg(`PMC_ADDR_POWER_CONTROL, d);
		chk(d, 8'h00);
		// Random overflow pulses under every enable combination
		m0 = 1'b0;
		m1 = 1'b0;
		for (b = 0; b < 4; b++) begin
			v = (8'($random(seed)) & 8'hf0) | 8'(b);
			wr_reg(`PMC_ADDR_CLKO_WAKE, v);
			rd_reg(`PMC_ADDR_CLKO_WAKE, d);
			chk(d, v & `PMC_CW_WRITE_MASK);
			for (i = 0; i < 12; i++) begin
				r0 = 1'($random(seed));
				r1 = 1'($random(seed));
				m0 = m0 ^ (r0 & v[0]);
				m1 = m1 ^ (r1 & v[1]);
				@(posedge clk);
				ov0 <= r0;
				ov1 <= r1;
				@(posedge clk);
				ov0 <= 1'b0;
				ov1 <= 1'b0;
			end
			repeat (3) @(posedge clk);
			#1;
			chk({6'h00, clko1, clko0}, {6'h00, m1, m0});
		end
		// Idle entry and exit by each interrupt source
		for (k = 0; k < 4; k++) begin
			@(posedge clk);
			cap_run <= k[0];
			wr_reg(`PMC_ADDR_POWER_CONTROL, 8'h01);
			rd_reg(`PMC_ADDR_POWER_CONTROL, d);
			chk(d, 8'h01);
			count(16);
			chk(8'(n_cpu), 8'h00);
			chk(8'(n_per), 8'h10);
			chk(8'(n_cap), 8'(16 * k[0]));
			@(posedge clk);
			irqs <= 4'(1 << k);
			@(posedge clk);
			irqs <= 4'h0;
			rd_reg(`PMC_ADDR_POWER_CONTROL, d);
			chk(d, 8'h00);
			count(16);
			chk(8'(n_cpu), 8'h10);
		end
		// Power-down and wake by an edge on each pin; first entry sets both bits
		wr_reg(`PMC_ADDR_CLKO_WAKE, 8'hf0);
		for (k = 0; k < 9; k++) begin
			wr_reg(`PMC_ADDR_POWER_CONTROL, (k == 0) ? 8'h03 : 8'h02);
			rd_reg(`PMC_ADDR_POWER_CONTROL, d);
			chk(d, 8'h02);
			count(8);
			chk(8'(n_per), 8'h00);
			chk(8'(osc_stop), 8'h01);
			@(posedge clk);
			pins <= pins ^ (9'h001 << k);
			repeat (8) @(posedge clk);
			#1;
			chk(8'(osc_stop), 8'h00);
		end
		close_out();
	end
endmodule
`default_nettype wire
